// File: common/elss_map.svh
// Register offsets, field positions, reset values and bus answer codes for the line source selector.
`ifndef ELSS_MAP_SVH
`define ELSS_MAP_SVH

// ---------------------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------------------
`define ELSS_OFF_SEL_LO     12'h004
`define ELSS_OFF_SEL_HI     12'h008
`define ELSS_OFF_LINE_STAT  12'h00c

// ---------------------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------------------
`define ELSS_FLD0_LSB       0
`define ELSS_FLD1_LSB       4
`define ELSS_FLD2_LSB       8
`define ELSS_FLD3_LSB       12
`define ELSS_SEL_MASK       32'h00003333
`define ELSS_SEL_RESET      32'h00000000
`define ELSS_NUM_PIN_LINES  8
`define ELSS_NUM_LINES      13

// ---------------------------------------------------------------------------
// Bus answer codes
// ---------------------------------------------------------------------------
`define ELSS_RESP_OKAY      2'h0
`define ELSS_RESP_SLVERR    2'h2

`endif

// File: common/elss_pkg.sv
// Types shared by the line source selector design files.
package elss_pkg;
    typedef logic [1:0]  elss_code_t;
    typedef logic [31:0] elss_word_t;
    typedef logic [11:0] elss_addr_t;
    typedef logic [13:0] elss_pin_t;
    typedef enum logic [1:0] {
        ELSS_CODE_FIRST,
        ELSS_CODE_SECOND,
        ELSS_CODE_THIRD,
        ELSS_CODE_RSVD
    } elss_code_e;
    typedef enum {
        ELSS_RD_IDLE,
        ELSS_RD_RESP
    } elss_rd_e;
endpackage

// File: design/elss_line_mux.sv
// One routed line: picks a pin by its two-bit code and registers the result.
`timescale 1ns/1ns
`include "elss_map.svh"

module elss_line_mux (
    input  wire logic                 CLK,    // Peripheral bus clock.
    input  wire logic                 RSTN,   // Synchronous reset, active low.
    input  wire logic                 CE,     // Clock enable.
    input  wire elss_pkg::elss_code_t code,   // Source selection code.
    input  wire logic [2:0]           pins,   // Candidate pins for codes 0 to 2.
    output logic                      line    // Registered routed line.
);
    import elss_pkg::*;

    logic next_line;

    // Reserved code gives a constant low, so no edge can reach the controller.
    // reserved codes low
    always_comb begin
        case (code)
            2'h0:    next_line = pins[0];
            2'h1:    next_line = pins[1];
            2'h2:    next_line = pins[2];
            default: next_line = 1'b0;
        endcase
    end

    // Output register keeps the routed line glitch free.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            line <= 1'b0;
        end else if (CE) begin
            line <= next_line;
        end
    end
endmodule

// File: design/elss_top.sv
// External line source selector: pin routing to lines 0..7 and request grouping.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "elss_map.svh"


module elss_top (
    input  wire logic                 CLK,            // 10 MHz bus clock.
    input  wire logic                 RSTN,           // Synchronous reset, active low.
    input  wire logic                 CE,             // Clock enable; low freezes state.
    input  wire logic [11:0]          AWADDR,         // Write address.
    input  wire logic                 AWVALID,        // Write address valid.
    output logic                      AWREADY,        // Write address ready.
    input  wire logic [31:0]          WDATA,          // Write data.
    input  wire logic [3:0]           WSTRB,          // Write byte strobes.
    input  wire logic                 WVALID,         // Write data valid.
    output logic                      WREADY,         // Write data ready.
    output logic [1:0]                BRESP,          // Write response.
    output logic                      BVALID,         // Write response valid.
    input  wire logic                 BREADY,         // Write response ready.
    input  wire logic [11:0]          ARADDR,         // Read address.
    input  wire logic                 ARVALID,        // Read address valid.
    output logic                      ARREADY,        // Read address ready.
    output logic [31:0]               RDATA,          // Read data.
    output logic [1:0]                RRESP,          // Read response.
    output logic                      RVALID,         // Read data valid.
    input  wire logic                 RREADY,         // Read data ready.
    input  wire elss_pkg::elss_pin_t  PORT_A_PINS,    // Port A pin levels.
    input  wire elss_pkg::elss_pin_t  PORT_B_PINS,    // Port B pin levels.
    input  wire logic                 RTC_ALARM_IRQ,  // Clock alarm source.
    input  wire logic                 RTC_WAKE_IRQ,   // Clock wake source.
    input  wire logic                 LP_SERIAL_IRQ,  // Low-power serial port source.
    input  wire logic                 RADIO_WAKE_IRQ, // Radio sleep wake source.
    input  wire logic                 LINE12_SRC,     // Line 12 source.
    input  wire logic [12:0]          LINE_PEND,      // Pending lines from controller.
    output logic [7:0]                PIN_LINES,      // Routed lines 0 to 7.
    output logic [3:0]                INT_LINES,      // Lines 8 to 11.
    output logic                      LINES_0_TO_1_IRQ,  // Lines 0-1 request.
    output logic                      LINES_2_TO_3_IRQ,  // Lines 2-3 request.
    output logic                      LINES_4_TO_12_IRQ  // Lines 4-12 request.
);
    import elss_pkg::*;

    // -----------------------------------------------------------------------
    // Register storage
    // -----------------------------------------------------------------------
    elss_word_t ext_line_src_sel_lo;
    elss_word_t ext_line_src_sel_hi;
    elss_addr_t wr_addr;
    elss_word_t wr_data;
    logic [3:0] wr_strb;
    logic       aw_held;
    logic       w_held;
    elss_rd_e   rd_state;
    elss_word_t next_rdata;
    logic [1:0] next_rresp;

    logic        wr_fire;
    logic        wr_hit;
    elss_word_t  wr_merge;
    elss_code_t  codes [8];
    logic [2:0]  cand  [8];

    // Write fires once both address and data are held and no response waits.
    assign wr_fire  = aw_held && w_held && !BVALID;
    assign wr_hit   = (wr_addr == `ELSS_OFF_SEL_LO) || (wr_addr == `ELSS_OFF_SEL_HI);

    // Byte-lane merge of write data onto the current register value.
    always_comb begin
        elss_word_t cur;
        cur = (wr_addr == `ELSS_OFF_SEL_HI) ? ext_line_src_sel_hi : ext_line_src_sel_lo;
        for (int i = 0; i < 4; i++) begin
            wr_merge[8*i +: 8] = wr_strb[i] ? wr_data[8*i +: 8] : cur[8*i +: 8];
        end
    end

    // -----------------------------------------------------------------------
    // Write channel
    // -----------------------------------------------------------------------
    // Address and data are taken in either order and held until the write fires.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            wr_addr <= 12'h000;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end else if (CE) begin
            if (AWVALID && AWREADY) begin
                aw_held <= 1'b1;
                wr_addr <= {AWADDR[11:2], 2'b00};
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (WVALID && WREADY) begin
                w_held  <= 1'b1;
                wr_data <= WDATA;
                wr_strb <= WSTRB;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    // Ready is a flop; it drops the cycle after a beat is taken.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            AWREADY <= 1'b0;
            WREADY  <= 1'b0;
        end else if (CE) begin
            AWREADY <= !aw_held && !(AWVALID && AWREADY) && !BVALID;
            WREADY  <= !w_held && !(WVALID && WREADY) && !BVALID;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ext_line_src_sel_lo <= `ELSS_SEL_RESET;
            ext_line_src_sel_hi <= `ELSS_SEL_RESET;
        end else if (CE && wr_fire) begin
            if (wr_addr == `ELSS_OFF_SEL_LO) begin
                ext_line_src_sel_lo <= wr_merge & `ELSS_SEL_MASK;
            end
            if (wr_addr == `ELSS_OFF_SEL_HI) begin
                ext_line_src_sel_hi <= wr_merge & `ELSS_SEL_MASK;
            end
        end
    end

    // Response; unmapped addresses answer with a slave error.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            BVALID <= 1'b0;
            BRESP  <= `ELSS_RESP_OKAY;
        end else if (CE) begin
            if (wr_fire) begin
                BVALID <= 1'b1;
                BRESP  <= wr_hit ? `ELSS_RESP_OKAY : `ELSS_RESP_SLVERR;
            end else if (BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------------
    // Read channel
    // -----------------------------------------------------------------------
    // Read decode; the status word shows which lines the controller holds pending.
    always_comb begin
        next_rresp = `ELSS_RESP_OKAY;
        case ({ARADDR[11:2], 2'b00})
            `ELSS_OFF_SEL_LO:    next_rdata = ext_line_src_sel_lo;
            `ELSS_OFF_SEL_HI:    next_rdata = ext_line_src_sel_hi;
            `ELSS_OFF_LINE_STAT: next_rdata = {19'h0, LINE_PEND};
            default: begin
                next_rdata = 32'h00000000;
                next_rresp = `ELSS_RESP_SLVERR;
            end
        endcase
    end

    // One read at a time: address taken, data shown the next cycle.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            rd_state <= ELSS_RD_IDLE;
            ARREADY  <= 1'b0;
            RVALID   <= 1'b0;
            RDATA    <= 32'h00000000;
            RRESP    <= `ELSS_RESP_OKAY;
        end else if (CE) begin
            case (rd_state)
                ELSS_RD_IDLE: begin
                    ARREADY <= !(ARVALID && ARREADY);
                    if (ARVALID && ARREADY) begin
                        RVALID   <= 1'b1;
                        RDATA    <= next_rdata;
                        RRESP    <= next_rresp;
                        rd_state <= ELSS_RD_RESP;
                    end
                end
                ELSS_RD_RESP: begin
                    ARREADY <= 1'b0;
                    if (RREADY) begin
                        RVALID   <= 1'b0;
                        rd_state <= ELSS_RD_IDLE;
                    end
                end
                default: rd_state <= ELSS_RD_IDLE;
            endcase
        end
    end

    // -----------------------------------------------------------------------
    // Pin routing
    // -----------------------------------------------------------------------
    // line 0 candidates
    assign cand[0] = {PORT_B_PINS[0], PORT_A_PINS[1], PORT_A_PINS[0]};
    assign cand[1] = {PORT_B_PINS[1], PORT_A_PINS[3], PORT_A_PINS[2]};
    assign cand[2] = {1'b0, PORT_B_PINS[2], PORT_A_PINS[6]};
    assign cand[3] = {1'b0, PORT_B_PINS[3], PORT_A_PINS[5]};
    assign cand[4] = {1'b0, PORT_B_PINS[4], PORT_B_PINS[9]};
    assign cand[5] = {PORT_B_PINS[5], PORT_B_PINS[11], PORT_B_PINS[10]};
    assign cand[6] = {PORT_A_PINS[4], PORT_B_PINS[6], PORT_B_PINS[12]};
    assign cand[7] = {PORT_B_PINS[8], PORT_B_PINS[7], PORT_B_PINS[13]};

    // Codes 10 of lines 2 to 4 are reserved too, so their third candidate must read low.
    assign codes[0] = ext_line_src_sel_lo[`ELSS_FLD0_LSB +: 2];
    assign codes[1] = ext_line_src_sel_lo[`ELSS_FLD1_LSB +: 2];
    assign codes[2] = ext_line_src_sel_lo[`ELSS_FLD2_LSB +: 2];
    assign codes[3] = ext_line_src_sel_lo[`ELSS_FLD3_LSB +: 2];
    assign codes[4] = ext_line_src_sel_hi[`ELSS_FLD0_LSB +: 2];
    assign codes[5] = ext_line_src_sel_hi[`ELSS_FLD1_LSB +: 2];
    assign codes[6] = ext_line_src_sel_hi[`ELSS_FLD2_LSB +: 2];
    assign codes[7] = ext_line_src_sel_hi[`ELSS_FLD3_LSB +: 2];

    for (genvar g = 0; g < `ELSS_NUM_PIN_LINES; g++) begin : g_line
        elss_line_mux u_mux (
            .CLK  (CLK),
            .RSTN (RSTN),
            .CE   (CE),
            .code (codes[g]),
            .pins (cand[g]),
            .line (PIN_LINES[g])
        );
    end

    // -----------------------------------------------------------------------
    // Internal lines and request grouping
    // -----------------------------------------------------------------------
    // clock alarm and wake sources on 8, 9
    // serial and radio on 10, 11
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            INT_LINES         <= 4'h0;
            LINES_0_TO_1_IRQ  <= 1'b0;
            LINES_2_TO_3_IRQ  <= 1'b0;
            LINES_4_TO_12_IRQ <= 1'b0;
        end else if (CE) begin
            INT_LINES         <= {RADIO_WAKE_IRQ, LP_SERIAL_IRQ, RTC_WAKE_IRQ, RTC_ALARM_IRQ};
            LINES_0_TO_1_IRQ  <= |LINE_PEND[1:0];
            LINES_2_TO_3_IRQ  <= |LINE_PEND[3:2];
            LINES_4_TO_12_IRQ <= |LINE_PEND[12:4];
        end
    end

    // -----------------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------------
    a_rsvd_line_low: assert property (@(posedge CLK) disable iff (!RSTN)
        (CE && codes[0] == 2'h3) |=> !PIN_LINES[0]) else $error("reserved code drove line");
    a_line0_route: assert property (@(posedge CLK) disable iff (!RSTN)
        (CE && codes[0] == 2'h2) |=> PIN_LINES[0] == $past(PORT_B_PINS[0]))
        else $error("line 0 route wrong");
    a_line2_rsvd: assert property (@(posedge CLK) disable iff (!RSTN)
        (CE && codes[2] == 2'h2) |=> !PIN_LINES[2]) else $error("line 2 code 10 not low");
    a_line6_route: assert property (@(posedge CLK) disable iff (!RSTN)
        (CE && codes[6] == 2'h2) |=> PIN_LINES[6] == $past(PORT_A_PINS[4]))
        else $error("line 6 route wrong");
    a_line7_route: assert property (@(posedge CLK) disable iff (!RSTN)
        (CE && codes[7] == 2'h0) |=> PIN_LINES[7] == $past(PORT_B_PINS[13]))
        else $error("line 7 route wrong");
    a_group_high: assert property (@(posedge CLK) disable iff (!RSTN)
        (CE && LINE_PEND[12]) |=> LINES_4_TO_12_IRQ) else $error("line 12 not grouped");
    a_rtc_lines: assert property (@(posedge CLK) disable iff (!RSTN)
        CE |=> INT_LINES[1:0] == $past({RTC_WAKE_IRQ, RTC_ALARM_IRQ}))
        else $error("clock lines wrong");
    a_radio_line: assert property (@(posedge CLK) disable iff (!RSTN)
        CE |=> INT_LINES[3] == $past(RADIO_WAKE_IRQ)) else $error("radio line wrong");
    a_sel_write: assert property (@(posedge CLK) disable iff (!RSTN)
        (CE && wr_fire && wr_addr == `ELSS_OFF_SEL_HI && wr_strb == 4'hf)
        |=> ext_line_src_sel_hi == ($past(wr_data) & `ELSS_SEL_MASK))
        else $error("selector write lost");
    a_serial_line: assert property (@(posedge CLK) disable iff (!RSTN)
        CE |=> INT_LINES[2] == $past(LP_SERIAL_IRQ)) else $error("serial line wrong");
    a_line4_rsvd: assert property (@(posedge CLK) disable iff (!RSTN)
        (CE && codes[4] == 2'h2) |=> !PIN_LINES[4]) else $error("line 4 code 10 not low");
    a_line5_route: assert property (@(posedge CLK) disable iff (!RSTN)
        (CE && codes[5] == 2'h1) |=> PIN_LINES[5] == $past(PORT_B_PINS[11]))
        else $error("line 5 route wrong");
endmodule

// File: test/elss_ctrl_model.sv
// Behavioural model of the edge-capturing line controller that the selector feeds.
`timescale 1ns/1ns

module elss_ctrl_model (
    input  wire logic        clk,       // Bus clock.
    input  wire logic        rstn,      // Synchronous reset, active low.
    input  wire logic [7:0]  pin_lines, // Routed lines 0 to 7.
    input  wire logic [3:0]  int_lines, // Internal lines 8 to 11.
    input  wire logic        line12,    // Line 12 source.
    input  wire logic        clr,       // Clears every pending bit.
    output logic [12:0]      pend       // Pending lines.
);
    logic [12:0] prev;
    logic [12:0] now_lines;

    assign now_lines = {line12, int_lines, pin_lines};

    // Rising edges set pending bits; falling edges are ignored, so a bench that
    // releases a pin never sees a second request from the same line.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prev <= 13'h0;
            pend <= 13'h0;
        end else begin
            prev <= now_lines;
            pend <= (clr ? 13'h0 : pend) | (now_lines & ~prev);
        end
    end
endmodule

// File: test/tb_top.sv
// Self-checking bench for the line source selector and its request grouping.
`timescale 1ns/1ns

module tb_top;
    logic        CLK = 1'b0;
    logic        RSTN = 1'b0;
    logic        CE = 1'b1;
    logic [11:0] AWADDR = 12'h0, ARADDR = 12'h0;
    logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic [31:0] WDATA = 32'h0, RDATA;
    logic [3:0]  WSTRB = 4'hf;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [1:0]  BRESP, RRESP;
    logic [13:0] PORT_A_PINS = 14'h0, PORT_B_PINS = 14'h0;
    logic [3:0]  SRC = 4'h0; // Radio, serial, clock wake, clock alarm.
    logic        LINE12_SRC = 1'b0, PEND_CLR = 1'b0;
    logic [12:0] LINE_PEND;
    logic [7:0]  PIN_LINES, exp_lines;
    logic [3:0]  INT_LINES;
    logic        IRQ01, IRQ23, IRQ412;
    int          n_errors = 0, tests_run = 0;
    // Pin number per line and code: port A pins 0..13, port B pins 14..27, 99 none.
    int tab [8][4] = '{'{0, 1, 14, 99}, '{2, 3, 15, 99}, '{6, 16, 99, 99},
        '{5, 17, 99, 99}, '{23, 18, 99, 99}, '{24, 25, 19, 99},
        '{26, 20, 4, 99}, '{27, 21, 22, 99}};

    // ---------------------------------------------------------------
    // Clock, design and far-side model
    // ---------------------------------------------------------------
    // The clock toggles every half period of 100 ns.
    always #50 CLK = ~CLK;

    elss_top elss_top_inst (.CLK(CLK), .RSTN(RSTN), .CE(CE), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
        .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
        .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .PORT_A_PINS(PORT_A_PINS),
        .PORT_B_PINS(PORT_B_PINS), .RTC_ALARM_IRQ(SRC[0]), .RTC_WAKE_IRQ(SRC[1]),
        .LP_SERIAL_IRQ(SRC[2]), .RADIO_WAKE_IRQ(SRC[3]), .LINE12_SRC(LINE12_SRC),
        .LINE_PEND(LINE_PEND), .PIN_LINES(PIN_LINES), .INT_LINES(INT_LINES),
        .LINES_0_TO_1_IRQ(IRQ01), .LINES_2_TO_3_IRQ(IRQ23), .LINES_4_TO_12_IRQ(IRQ412));

    elss_ctrl_model elss_ctrl_model_inst (.clk(CLK), .rstn(RSTN), .pin_lines(PIN_LINES),
        .int_lines(INT_LINES), .line12(LINE12_SRC), .clr(PEND_CLR), .pend(LINE_PEND));

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bus write; outputs are read right after the edge, before it updates them.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge CLK);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge CLK);
            if (!aw_done && AWREADY === 1'b1) begin
                aw_done = 1'b1;
                AWVALID <= 1'b0;
            end
            if (!w_done && WREADY === 1'b1) begin
                w_done = 1'b1;
                WVALID <= 1'b0;
            end
        end
        do @(posedge CLK); while (BVALID !== 1'b1);
        BREADY <= 1'b0;
        chk({30'h0, BRESP}, {30'h0, er});
    endtask

    // Bus read with expected data and response.
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do @(posedge CLK); while (ARREADY !== 1'b1);
        ARVALID <= 1'b0;
        do @(posedge CLK); while (RVALID !== 1'b1);
        RREADY <= 1'b0;
        chk(RDATA, ed);
        chk({30'h0, RRESP}, {30'h0, er});
    endtask

    // Checks the three grouped requests against the lines expected to fire.
    task automatic chk_irq(input logic [12:0] l);
        chk({29'h0, IRQ412, IRQ23, IRQ01}, {29'h0, |l[12:4], |l[3:2], |l[1:0]});
    endtask

    // Releases every source and empties the controller model.
    task automatic release_all;
        PORT_A_PINS <= 14'h0;
        PORT_B_PINS <= 14'h0;
        SRC <= 4'h0;
        LINE12_SRC <= 1'b0;
        PEND_CLR <= 1'b1;
        @(posedge CLK);
        PEND_CLR <= 1'b0;
        repeat (3) @(posedge CLK);
    endtask

    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // The whole run needs about a thousand cycles; this bound only cuts a hang.
    initial begin
        repeat (20000) @(posedge CLK);
        n_errors++;
        end_sim;
    end

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial begin
        repeat (10) @(posedge CLK);
        RSTN <= 1'b1;
        rd(12'h004, 32'h0, 2'h0);
        rd(12'h008, 32'h0, 2'h0);
        rd(12'h000, 32'h0, 2'h2);
        wr(12'h000, 32'hffffffff, 2'h2);
        // With the clock enable low nothing may move; once it is high the pin routes.
        CE <= 1'b0;
        PORT_A_PINS <= 14'h1;
        repeat (4) @(posedge CLK);
        chk({24'h0, PIN_LINES}, 32'h0);
        CE <= 1'b1;
        repeat (4) @(posedge CLK);
        chk({24'h0, PIN_LINES}, 32'h1);
        release_all;
        $display("test reset and decode done");
        // Every code on every line, with each of the 28 pins raised alone.
        for (int c = 0; c < 4; c++) begin
            wr(12'h004, 32'(c) * 32'h11111111, 2'h0);
            wr(12'h008, 32'(c) * 32'h11111111, 2'h0);
            rd(12'h004, 32'(c) * 32'h00001111, 2'h0);
            rd(12'h008, 32'(c) * 32'h00001111, 2'h0);
            for (int p = 0; p < 28; p++) begin
                for (int m = 0; m < 8; m++) begin
                    exp_lines[m] = (tab[m][c] == p);
                end
                PORT_A_PINS <= (p < 14) ? 14'(1) << p : 14'h0;
                PORT_B_PINS <= (p < 14) ? 14'h0 : 14'(1) << (p - 14);
                repeat (4) @(posedge CLK);
                chk({24'h0, PIN_LINES}, {24'h0, exp_lines});
                chk_irq({5'h0, exp_lines});
                release_all;
            end
        end
        // A write to byte 1 only must leave the fields of byte 0 untouched.
        WSTRB <= 4'h2;
        wr(12'h004, 32'h00000000, 2'h0);
        rd(12'h004, 32'h00000033, 2'h0);
        WSTRB <= 4'hf;
        // A second reset in mid-run must clear both selectors again.
        RSTN <= 1'b0;
        repeat (2) @(posedge CLK);
        RSTN <= 1'b1;
        rd(12'h004, 32'h0, 2'h0);
        rd(12'h008, 32'h0, 2'h0);
        $display("test pin routing done");
        // Internal sources occupy lines 8 to 11 and join the third request.
        for (int k = 0; k < 4; k++) begin
            SRC <= 4'(1) << k;
            repeat (4) @(posedge CLK);
            chk({28'h0, INT_LINES}, 32'(1) << k);
            chk_irq(13'(1) << (k + 8));
            release_all;
        end
        LINE12_SRC <= 1'b1;
        repeat (4) @(posedge CLK);
        chk_irq(13'h1000);
        rd(12'h00c, 32'h00001000, 2'h0);
        release_all;
        chk_irq(13'h0);
        $display("test internal lines done");
        end_sim;
    end
endmodule
